/* File: logic/cil_pkg.sv */
// constants and types for the instruction length and timing decoder
package cil_pkg;

  // machine cycle sequencing: oscillator clocks per machine cycle
  localparam int unsigned MCYC_CLKS = 12;
  localparam logic [3:0]  MCYC_LAST = 4'hB;

  // value of the program counter after reset
  localparam logic [15:0] PC_RESET  = 16'h0000;

  // byte index and counter resets
  localparam logic [1:0]  IDX_RESET = 2'h0;
  localparam logic [1:0]  MCYC_RST  = 2'h0;
  localparam logic [3:0]  MCLK_RST  = 4'h0;

  // fetch and execute sequencer
  typedef enum logic [1:0] {
    ST_REQ  = 2'b00,
    ST_WAIT = 2'b01,
    ST_EXEC = 2'b10,
    ST_DONE = 2'b11
  } cil_state_t;

  // how an instruction changes the flow of control
  typedef enum logic [2:0] {
    BK_NONE     = 3'b000,
    BK_REL_ALL  = 3'b001,
    BK_REL_COND = 3'b010,
    BK_ABS      = 3'b011,
    BK_LONG     = 3'b100,
    BK_INDIRECT = 3'b101,
    BK_RETURN   = 3'b110
  } cil_branch_t;

endpackage

/* File: logic/cil_decoder.sv */
// instruction length, timing and flow decoder for an 8-bit core
// Behaviour
// [RULE1] add_with_carry forms: 1/2 bytes, 1 cycle
// [RULE2] subtract_with_borrow forms: 1/2 bytes, 1 cycle
// [RULE3] data_pointer_16 increment 1 byte, 2 cycles
// [RULE4] multiply/divide by B: 1 byte, 4 cycles
// [RULE5] logic op immediate to direct: 3 bytes, 2 cycles
// [RULE6] rotates, clear, complement accumulator: 1/1
// [RULE7] nibble swap: one byte, one cycle
// [RULE8] register/direct moves two bytes, two cycles
// [RULE9] direct-direct, immediate-direct moves: 3 bytes, 2 cycles
// [RULE10] load data_pointer_16 immediate: 3 bytes, 2 cycles
// [RULE11] code_memory_read: 1 byte, 2 cycles
// [RULE12] external_ram_move forms: 1 byte, 2 cycles
// [RULE13] push and pop: 2 bytes, 2 cycles
// [RULE14] exchanges one cycle; exchange_low_digit 1/1
// [RULE15] carry bit logic 2/2; bit set/clear 1 cycle
// [RULE16] carry to bit 2/2; bit to carry 2/1
// [RULE17] calls 2/3 bytes, returns 1; all 2 cycles
// [RULE18] jumps: 2, 3 or 1 bytes; 2 cycles
// [RULE19] conditional jumps 2 cycles; bit forms 3 bytes
// [RULE20] compare_jump_not_equal: 3 bytes, 2 cycles
// [RULE21] relative offset signed, from next instruction
// [RULE22] absolute target within next instruction's 2K page
// [RULE23] advance past all bytes before computing targets
`timescale 1ns/1ps

module cil_decoder
  import cil_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // program memory
  output logic             o_code_rd,
  output logic [15:0]      o_code_addr,
  input  wire logic        i_code_valid,
  input  wire logic [7:0]  i_code_byte,
  // execution side answers
  input  wire logic        i_cond_true,
  input  wire logic [15:0] i_jump_addr,
  // decoded instruction report
  output logic             o_insn_done,
  output logic [7:0]       o_opcode,
  output logic [1:0]       o_insn_len,
  output logic [2:0]       o_insn_cycles,
  output logic [2:0]       o_branch_kind,
  output logic             o_branch_taken,
  output logic             o_is_call,
  output logic [15:0]      o_insn_addr,
  output logic [15:0]      o_pc
);

  // encoded length in bytes, by opcode column then row
  function automatic logic [1:0] insn_len(input logic [7:0] op);
    logic [3:0] row;
    row = op[7:4];
    insn_len = 2'h1;
    if (op[3]) begin
      // working_register column: moves, compare_jump, decrement_jump
      if (row == 4'hB) insn_len = 2'h3; // [RULE20]
      else if (row inside {4'h7, 4'h8, 4'hA, 4'hD}) insn_len = 2'h2; // [RULE8]
    end else begin
      unique case (op[2:0])
        3'h0: begin
          if (row inside {4'h1, 4'h2, 4'h3, 4'h9}) insn_len = 2'h3; // [RULE19] [RULE10]
          else if (row inside {4'h0, 4'hE, 4'hF}) insn_len = 2'h1; // [RULE12]
          else insn_len = 2'h2; // [RULE13] [RULE15] [RULE18]
        end
        3'h1: insn_len = 2'h2; // [RULE17] [RULE18]
        3'h2: begin
          if (row inside {4'h0, 4'h1}) insn_len = 2'h3; // [RULE17] [RULE18]
          else if (row inside {4'h2, 4'h3, 4'hE, 4'hF}) insn_len = 2'h1;
          else insn_len = 2'h2; // [RULE15] [RULE16]
        end
        3'h3: begin
          if (row inside {4'h4, 4'h5, 4'h6}) insn_len = 2'h3; // [RULE5]
          else insn_len = 2'h1; // [RULE6] [RULE11]
        end
        3'h4: begin
          if (row == 4'hB) insn_len = 2'h3; // [RULE20]
          else if (row inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9})
            insn_len = 2'h2; // [RULE1] [RULE2]
          else insn_len = 2'h1; // [RULE4] [RULE7]
        end
        3'h5: begin
          if (row == 4'hA) insn_len = 2'h1; // reserved code, treat as one
          else if (row inside {4'h7, 4'h8, 4'hB, 4'hD}) insn_len = 2'h3; // [RULE9]
          else insn_len = 2'h2; // [RULE1] [RULE2] [RULE14]
        end
        default: begin
          // indirect_pointer_register columns
          if (row == 4'hB) insn_len = 2'h3;
          else if (row inside {4'h7, 4'h8, 4'hA}) insn_len = 2'h2;
          else insn_len = 2'h1; // [RULE14]
        end
      endcase
    end
  endfunction

  // execution length in machine cycles: 1, 2 or 4
  function automatic logic [2:0] insn_cycles(input logic [7:0] op);
    logic [3:0] row;
    row = op[7:4];
    insn_cycles = 3'h1;
    if (op[3]) begin
      if (row inside {4'h8, 4'hA, 4'hB, 4'hD}) insn_cycles = 3'h2; // [RULE8]
    end else begin
      unique case (op[2:0])
        3'h0: if (row != 4'h0) insn_cycles = 3'h2; // [RULE13] [RULE19]
        3'h1: insn_cycles = 3'h2; // [RULE17] [RULE18]
        3'h2: begin
          if (row inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hE,
                          4'hF})
            insn_cycles = 3'h2; // [RULE15] [RULE16] [RULE12]
        end
        3'h3: begin
          if (row inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hE,
                          4'hF})
            insn_cycles = 3'h2; // [RULE3] [RULE5] [RULE11]
        end
        3'h4: begin
          if (row inside {4'h8, 4'hA}) insn_cycles = 3'h4; // [RULE4]
          else if (row == 4'hB) insn_cycles = 3'h2; // [RULE20]
        end
        3'h5: if (row inside {4'h7, 4'h8, 4'hB, 4'hD}) insn_cycles = 3'h2; // [RULE9]
        default: if (row inside {4'h8, 4'hA, 4'hB}) insn_cycles = 3'h2;
      endcase
    end
  endfunction

  // flow of control class of an opcode
  function automatic cil_branch_t branch_kind(input logic [7:0] op);
    branch_kind = BK_NONE;
    if (op[3:0] == 4'h1) branch_kind = BK_ABS;
    else if (op inside {8'h02, 8'h12}) branch_kind = BK_LONG;
    else if (op == 8'h80) branch_kind = BK_REL_ALL;
    else if (op inside {8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70,
                        8'hD5} || op[7:3] == 5'h1B ||
             (op[7:4] == 4'hB && op[3:2] != 2'h0))
      branch_kind = BK_REL_COND; // [RULE19] [RULE20]
    else if (op == 8'h73) branch_kind = BK_INDIRECT;
    else if (op inside {8'h22, 8'h32}) branch_kind = BK_RETURN;
  endfunction

  cil_state_t  state_reg;
  logic [1:0]  idx_reg;
  logic [7:0]  bytes_reg [3];
  logic [1:0]  len_reg;
  logic [2:0]  cyc_reg;
  logic [15:0] pc_reg;
  logic [3:0]  mclk_reg;
  logic [1:0]  mcyc_reg;
  logic [1:0]  len_now;
  logic        last_byte;
  logic        exec_end;
  logic [15:0] pc_next;
  logic [7:0]  rel_off;
  cil_branch_t kind;
  logic        taken;
  logic [15:0] target;
  logic [15:0] pc_new;

  // length is known from the opcode byte as soon as it arrives
  assign len_now   = (idx_reg == IDX_RESET) ? insn_len(i_code_byte) : len_reg;
  assign last_byte = i_code_valid && (idx_reg == len_now - 2'h1);
  assign exec_end  = (mclk_reg == MCYC_LAST) &&
                     (mcyc_reg == 2'(cyc_reg - 3'h1));
  // pc past every byte of the instruction before any target [RULE23]
  assign pc_next   = pc_reg + {14'h0000, len_reg};
  assign rel_off   = bytes_reg[len_reg - 2'h1]; // offset is the last byte
  assign kind      = branch_kind(bytes_reg[0]);
  assign taken     = (kind != BK_NONE) &&
                     ((kind != BK_REL_COND) || i_cond_true);

  // target selection; never looks at pc_reg directly, only pc_next
  always_comb begin
    unique case (kind)
      BK_REL_ALL, BK_REL_COND:
        target = pc_next + {{8{rel_off[7]}}, rel_off}; // [RULE21]
      BK_ABS:
        target = {pc_next[15:11], bytes_reg[0][7:5], bytes_reg[1]}; // [RULE22]
      BK_LONG:
        target = {bytes_reg[1], bytes_reg[2]}; // [RULE17] [RULE18]
      default:
        target = i_jump_addr;
    endcase
    pc_new = taken ? target : pc_next;
  end

  // sequencer: fetch bytes one at a time, then run the machine cycles
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state_reg <= ST_REQ;
    end else begin
      unique case (state_reg)
        ST_REQ:  state_reg <= ST_WAIT;
        ST_WAIT: begin
          if (i_code_valid) state_reg <= last_byte ? ST_EXEC : ST_REQ;
        end
        ST_EXEC: if (exec_end) state_reg <= ST_DONE;
        ST_DONE: state_reg <= ST_REQ;
      endcase
    end
  end

  // byte capture; length and cycles latched from the opcode byte
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      idx_reg <= IDX_RESET;
      len_reg <= 2'h1;
      cyc_reg <= 3'h1;
      for (int i = 0; i < 3; i++) bytes_reg[i] <= 8'h00;
    end else if (state_reg == ST_WAIT && i_code_valid) begin
      bytes_reg[idx_reg] <= i_code_byte;
      if (idx_reg == IDX_RESET) begin
        len_reg <= insn_len(i_code_byte);
        cyc_reg <= insn_cycles(i_code_byte);
      end
      idx_reg <= last_byte ? IDX_RESET : idx_reg + 2'h1;
    end
  end

  // machine cycle counters; a four-cycle op holds the block longest
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || state_reg != ST_EXEC) begin
      mclk_reg <= MCLK_RST;
      mcyc_reg <= MCYC_RST;
    end else if (mclk_reg == MCYC_LAST) begin
      mclk_reg <= MCLK_RST;
      mcyc_reg <= mcyc_reg + 2'h1;
    end else begin
      mclk_reg <= mclk_reg + 4'h1;
    end
  end

  // program counter and memory read strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pc_reg      <= PC_RESET;
      o_code_rd   <= 1'b0;
      o_code_addr <= PC_RESET;
    end else begin
      o_code_rd <= (state_reg == ST_REQ);
      if (state_reg == ST_REQ) o_code_addr <= pc_reg + {14'h0000, idx_reg};
      if (state_reg == ST_DONE) pc_reg <= pc_new;
    end
  end

  // one-cycle report at the end of each instruction
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_insn_done    <= 1'b0;
      o_opcode       <= 8'h00;
      o_insn_len     <= 2'h1;
      o_insn_cycles  <= 3'h1;
      o_branch_kind  <= BK_NONE;
      o_branch_taken <= 1'b0;
      o_is_call      <= 1'b0;
      o_insn_addr    <= PC_RESET;
      o_pc           <= PC_RESET;
    end else begin
      o_insn_done <= (state_reg == ST_DONE);
      if (state_reg == ST_DONE) begin
        o_opcode       <= bytes_reg[0];
        o_insn_len     <= len_reg;
        o_insn_cycles  <= cyc_reg;
        o_branch_kind  <= kind;
        o_branch_taken <= taken;
        // calls push pc_next, so the caller sees it as o_insn_addr+len
        o_is_call      <= (bytes_reg[0][4:0] == 5'h11) ||
                          (bytes_reg[0] == 8'h12); // [RULE17]
        o_insn_addr    <= pc_reg;
        o_pc           <= pc_new;
      end
    end
  end

  // clocks spent executing, read only by the checks below
  logic [5:0] exec_clks_reg;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || state_reg == ST_REQ) exec_clks_reg <= 6'h00;
    else if (state_reg == ST_EXEC) exec_clks_reg <= exec_clks_reg + 6'h01;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_fetch_req;
    state_reg == ST_REQ;
  endsequence
  sequence s_read_pulse;
    o_code_rd ##1 !o_code_rd;
  endsequence

  a_read_strobe: assert property (s_fetch_req |=> s_read_pulse) // [RULE23]
    else $error("read strobe not a single pulse after request");
  a_exec_span: assert property ( // [RULE1]
    (state_reg == ST_EXEC ##1 state_reg == ST_DONE) |->
      exec_clks_reg == 6'(int'(cyc_reg) * MCYC_CLKS))
    else $error("execution span differs from machine cycles");
  a_muldiv_four: assert property ( // [RULE4]
    o_insn_done && o_opcode inside {8'h84, 8'hA4} |->
      o_insn_len == 2'h1 && o_insn_cycles == 3'h4)
    else $error("multiply or divide timing wrong");
  a_data_pointer_16_inc: assert property ( // [RULE3]
    o_insn_done && o_opcode == 8'hA3 |->
      o_insn_len == 2'h1 && o_insn_cycles == 3'h2)
    else $error("pointer increment timing wrong");
  a_logic_direct: assert property ( // [RULE5]
    o_insn_done && o_opcode inside {8'h43, 8'h53, 8'h63} |->
      o_insn_len == 2'h3 && o_insn_cycles == 3'h2)
    else $error("logic immediate to direct timing wrong");
  a_acc_unary: assert property ( // [RULE6]
    o_insn_done && o_opcode inside {8'h03, 8'h13, 8'h23, 8'h33, 8'hC4,
                                    8'hE4, 8'hF4} |->
      o_insn_len == 2'h1 && o_insn_cycles == 3'h1)
    else $error("accumulator unary timing wrong");
  a_compare_jump_not_equal_form: assert property ( // [RULE20]
    o_insn_done && o_opcode[7:4] == 4'hB && o_opcode[3:2] != 2'h0 |->
      o_insn_len == 2'h3 && o_insn_cycles == 3'h2 &&
      o_branch_kind == BK_REL_COND)
    else $error("compare jump decode wrong");
  a_pc_advance: assert property ( // [RULE23]
    o_insn_done && !o_branch_taken |->
      o_pc == o_insn_addr + {14'h0000, o_insn_len})
    else $error("program counter not past whole instruction");
  a_abs_page: assert property ( // [RULE22]
    o_insn_done && o_branch_kind == BK_ABS |->
      o_pc[15:11] == 5'((o_insn_addr + {14'h0000, o_insn_len}) >> 11))
    else $error("absolute target left its page");
  a_fetch_order: assert property ( // [RULE23]
    $rose(o_insn_done) |=> state_reg == ST_WAIT && o_code_rd &&
      o_code_addr == o_pc)
    else $error("next fetch not at new program counter");

endmodule // cil_decoder

/* File: testbench/cil_code_mem.sv */
// program memory model answering the decoder's byte fetches
`timescale 1ns/1ps

module cil_code_mem (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // fetch request and answer
  input  wire logic        i_code_rd,
  input  wire logic [15:0] i_code_addr,
  input  wire logic [1:0]  i_delay,
  output logic             o_code_valid,
  output logic [7:0]       o_code_byte
);
  logic [7:0]  mem [int];
  logic [15:0] addr_reg;
  int          wait_cnt;
  bit          busy;
  time         t_taken;

  // answer i_delay cycles late; a released bus shows the inverse byte so a
  // late sample by the decoder cannot pass by luck
  always @(negedge i_clk_sys) begin
    if (!i_resetn) begin
      busy = 1'b0;
      o_code_valid <= 1'b0;
      o_code_byte  <= 8'h00;
    end else if (o_code_valid) begin
      o_code_valid <= 1'b0;
      o_code_byte  <= ~o_code_byte;
    end else begin
      if (i_code_rd && !busy) begin
        busy = 1'b1;
        addr_reg = i_code_addr;
        wait_cnt = i_delay;
      end
      if (busy && wait_cnt == 0) begin
        busy = 1'b0;
        o_code_valid <= 1'b1;
        o_code_byte  <= mem.exists(addr_reg) ? mem[addr_reg] : ~addr_reg[7:0];
      end else if (busy) begin
        wait_cnt--;
      end
    end
  end

  // edge at which the decoder takes the byte
  always @(posedge i_clk_sys) begin
    if (o_code_valid) t_taken = $time;
  end
endmodule // cil_code_mem

/* File: testbench/test_cpu8_instruction_length_timing.sv */
// self-checking bench for the instruction length and timing decoder
`timescale 1ns/1ps

module test_cpu8_instruction_length_timing;
  import cil_pkg::*;
  logic        clk_sys, resetn, code_rd, code_valid, cond_true, insn_done;
  logic        branch_taken, is_call;
  logic [1:0]  delay, insn_len;
  logic [2:0]  insn_cycles, branch_kind;
  logic [7:0]  code_byte, opcode;
  logic [15:0] code_addr, jump_addr, insn_addr, pc, exp_pc;
  int          num_errors, total_checks;
  // entries: opcode, bytes, machine cycles, flow kind
  logic [19:0] tbl [$] = '{
    20'h35210, 20'h36110, 20'h34210, 20'h38110,
    20'h95210, 20'h96110, 20'h94210, 20'h9F110,
    20'hA3120, 20'h04110, 20'h05210, 20'h15210, 20'h18110,
    20'hA4140, 20'h84140,
    20'h43320, 20'h53320, 20'h63320, 20'h42210, 20'h58110,
    20'h23110, 20'h33110, 20'h03110, 20'h13110, 20'hE4110,
    20'hF4110, 20'hC4110,
    20'hA8220, 20'h88220, 20'h86220, 20'hA6220, 20'hE8110,
    20'hF8110, 20'h85320, 20'h75320, 20'h90320,
    20'h83120, 20'h93120, 20'hE0120, 20'hE2120, 20'hF0120,
    20'hF2120, 20'hC0220, 20'hD0220,
    20'hC8110, 20'hC5210, 20'hC6110, 20'hD6110,
    20'h72220, 20'hA0220, 20'h82220, 20'hB0220, 20'hC3110,
    20'hD3110, 20'hB3110, 20'hC2210, 20'hD2210, 20'hB2210,
    20'h92220, 20'hA2210,
    20'h11223, 20'hF1223, 20'h12324, 20'h22126, 20'h32126,
    20'h01223, 20'hE1223, 20'h02324, 20'h80221, 20'h73125,
    20'h60222, 20'h70222, 20'h40222, 20'h50222, 20'h20322,
    20'h30322, 20'h10322,
    20'hB4322, 20'hB5322, 20'hB6322, 20'hB8322};

  cil_decoder dut (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .o_code_rd(code_rd),
    .o_code_addr(code_addr), .i_code_valid(code_valid),
    .i_code_byte(code_byte), .i_cond_true(cond_true),
    .i_jump_addr(jump_addr), .o_insn_done(insn_done), .o_opcode(opcode),
    .o_insn_len(insn_len), .o_insn_cycles(insn_cycles),
    .o_branch_kind(branch_kind), .o_branch_taken(branch_taken),
    .o_is_call(is_call), .o_insn_addr(insn_addr), .o_pc(pc));

  cil_code_mem mem_u (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_code_rd(code_rd),
    .i_code_addr(code_addr), .i_delay(delay), .o_code_valid(code_valid),
    .o_code_byte(code_byte));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reset for three cycles, then check the idle report
  task automatic do_reset();
    @(negedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({code_rd, insn_done, branch_taken, is_call}, 16'h0000);
    chk({insn_len, insn_cycles, branch_kind}, 16'h0048);
    chk(pc, 16'h0000);
    resetn <= 1'b1;
    exp_pc = PC_RESET;
  endtask

  // place one instruction at the expected address and check its report
  task automatic run_insn(input int idx);
    logic [19:0] e;
    logic [7:0]  b1, b2, rel;
    logic [15:0] nxt, tgt;
    bit          cnd, seen;
    e = tbl[idx];
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    cnd = 1'($urandom);
    mem_u.mem[exp_pc] = e[19:12];
    mem_u.mem[16'(exp_pc + 1)] = b1;
    mem_u.mem[16'(exp_pc + 2)] = b2;
    @(negedge clk_sys);
    cond_true <= cnd;
    jump_addr <= 16'($urandom);
    delay     <= 2'($urandom);
    nxt = exp_pc + 16'(e[11:8]);
    // the offset is the last byte and counts from the next instruction
    rel = (e[11:8] == 4'h3) ? b2 : b1;
    seen = 1'b0;
    for (int n = 0; n < 300 && !seen; n++) begin
      @(posedge clk_sys);
      #1;
      seen = insn_done;
    end
    if (!seen) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    end
    case (e[3:0])
      4'h1, 4'h2: tgt = nxt + {{8{rel[7]}}, rel};
      4'h3: tgt = {nxt[15:11], e[19:17], b1};
      4'h4: tgt = {b1, b2};
      4'h5, 4'h6: tgt = jump_addr;
      default: tgt = nxt;
    endcase
    if (e[3:0] == 4'h2 && !cnd) tgt = nxt;
    chk(16'(opcode), 16'(e[19:12]));
    chk(16'(insn_len), 16'(e[11:8]));
    chk(16'(insn_cycles), 16'(e[7:4]));
    chk(16'(branch_kind), 16'(e[3:0]));
    chk(16'(branch_taken), 16'(e[3:0] != 0 && (e[3:0] != 2 || cnd)));
    chk(16'(is_call), 16'(e[19:12] == 8'h12 || e[16:12] == 5'h11));
    chk(insn_addr, exp_pc);
    chk(pc, tgt);
    // report lands 1 + 12 clocks per machine cycle after the last byte:
    // 12 clocks per machine cycle executing, one in the closing state
    chk(16'(($time - mem_u.t_taken) / 50), 16'(1 + 12 * e[7:4]));
    exp_pc = tgt;
  endtask

  // watchdog sized well beyond the longest expected run
  initial begin
    #(30000 * 50);
    num_errors++;
    close_out();
  end

  initial begin
    void'($urandom(99));
    resetn = 1'b0;
    cond_true = 1'b0;
    jump_addr = 16'h0000;
    delay = 2'h0;
    num_errors = 0;
    total_checks = 0;
    exp_pc = PC_RESET;
    do_reset();
    foreach (tbl[i]) run_insn(i);
    repeat (60) run_insn($urandom % tbl.size());
    // a second reset in mid-run restarts fetching from the reset address
    do_reset();
    repeat (20) run_insn($urandom % tbl.size());
    close_out();
  end
endmodule // test_cpu8_instruction_length_timing
